// file: rtl/bf_pkg.sv
// Package with constants, register map and carrier types of the breaker-failure timer logic.
package bf_pkg;

  // Clock rate and the timing step of both delay settings.
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned STEP_US       = 5_000;
  localparam int unsigned STEP_CYCLES   = (CLK_HZ / 1_000_000) * STEP_US;
  localparam int unsigned STEP_CNT_W    = 18;

  // Delay settings are counted in steps of 5 ms; 1800 s needs 360000 steps.
  localparam int unsigned DELAY_W       = 20;
  localparam int unsigned RETRIP_DEF_MS = 100;
  localparam int unsigned BF_DEF_MS     = 200;
  localparam logic [19:0] RETRIP_DEF    = 20'(RETRIP_DEF_MS * 1_000 / STEP_US);
  localparam logic [19:0] BF_DEF        = 20'(BF_DEF_MS * 1_000 / STEP_US);

  // Register offsets on the plain register port.
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_RETRIP     = 8'h04;
  localparam logic [7:0] OFS_BF         = 8'h08;
  localparam logic [7:0] OFS_STATUS     = 8'h0C;

  // Control register fields and reset values.
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_RT_EN    = 2;
  localparam logic        RT_EN_DEF     = 1'b1;

  // Status register fields.
  localparam int unsigned STAT_COND_LSB = 0;
  localparam int unsigned STAT_PH_BIT   = 8;
  localparam int unsigned STAT_RES_BIT  = 9;
  localparam int unsigned STAT_TRIP_BIT = 10;
  localparam int unsigned STAT_BLK_BIT  = 11;

  // Start criterion; code 2'b11 is illegal and behaves as current only.
  typedef enum logic [1:0] {
    MODE_CURRENT     = 2'b00,
    MODE_CUR_AND_DO  = 2'b01,
    MODE_CUR_OR_DO   = 2'b10
  } mode_t;

  // Function condition shown in the status register.
  typedef enum logic [4:0] {
    COND_NORMAL  = 5'b0_0001,
    COND_START   = 5'b0_0010,
    COND_RETRIP  = 5'b0_0100,
    COND_BF_ON   = 5'b0_1000,
    COND_BLOCKED = 5'b1_0000
  } cond_t;

  // Settings written by software.
  typedef struct packed {
    logic [1:0]  mode;
    logic        retrip_en;
    logic [19:0] retrip_delay_setting;
    logic [19:0] bf_delay;
  } cfg_t;

  // Over-threshold flags and monitor inputs sampled together.
  typedef struct packed {
    logic phase_over;
    logic residual_over;
    logic trip_monitor;
    logic block;
  } sense_t;

endpackage : bf_pkg

// file: rtl/step_tick_gen.sv
// Step tick generator: one pulse per 5 ms step while a pick-up is running.
`timescale 1ns/100ps
module step_tick_gen #(
  parameter logic [17:0] STEP_CYCLES = 18'(bf_pkg::STEP_CYCLES)
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic run_in,
  output logic      tick_out
);

  logic [17:0] cnt_q;
  logic [17:0] cnt_d;
  logic        tick_q;
  logic        tick_d;

  // Restarting from zero on every new pick-up keeps each delay a whole number of steps from the start.
  always_comb begin
    cnt_d  = 18'h0_0000;
    tick_d = 1'b0;
    if (run_in) begin
      if (cnt_q >= STEP_CYCLES - 18'h0_0001) begin
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 18'h0_0001;
      end
    end
  end

  // Registers of the step counter.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q  <= 18'h0_0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d & run_in;
    end
  end

  assign tick_out = tick_q & run_in; // A tick left over after the run ends is dropped.

endmodule : step_tick_gen

// file: rtl/delay_timer.sv
// Delay timer counting steps up to a programmed limit, with clear and saturation.
`timescale 1ns/100ps
module delay_timer (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        run_in,
  input  wire logic        tick_in,
  input  wire logic [19:0] limit_in,
  output logic             done_out
);

  logic [19:0] cnt_q;
  logic [19:0] cnt_d;

  // Not running clears the count; the count saturates at the limit.
  always_comb begin
    cnt_d = cnt_q;
    if (!run_in) begin
      cnt_d = 20'h0_0000;
    end else if (tick_in && (cnt_q < limit_in)) begin
      cnt_d = cnt_q + 20'h0_0001;
    end
  end

  // Count register.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 20'h0_0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // A limit lowered below the count while running expires at once.
  assign done_out = run_in && (cnt_q >= limit_in);

endmodule : delay_timer

// file: rtl/breaker_fail_timer_logic.sv
// Top of the breaker-failure supervision logic: criterion, timers, outputs and registers.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps

// The over-threshold flags arrive ready-made from the measuring front end, and the primary trip
// contact is seen only through its monitor input; this block only decides when the pick-up
// condition holds and for how long it has held.
//
// Both delays are counted in whole steps of one shared step tick. The step counter restarts at
// every new pick-up, so a delay of N steps lasts N full steps plus two clock cycles of pipeline,
// and a delay of zero steps shows its output together with the start indication.
//
// Settings may be changed while a pick-up runs. A limit moved below the elapsed count expires at
// once, which errs towards tripping rather than towards leaving a failed breaker in service.
//
// The indication outputs are levels. Start follows the unblocked pick-up, retrip and breaker fail
// follow their timers, and blocked shows a pick-up that the block input holds off. All of them
// fall in the cycle after the pick-up goes, so a cleared fault cannot leave a trip command standing.
//
// A block that arrives while a start is running drops the start and clears both timers; when the
// block goes, timing begins again from zero rather than carrying on from where it stopped.
//
// Software reaches the settings over a plain register port that answers every read in the next
// cycle and never makes the master wait.

module breaker_fail_timer_logic #(
  parameter int unsigned STEP_CYCLES = bf_pkg::STEP_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        phase_over_in,
  input  wire logic        residual_over_in,
  input  wire logic        trip_monitor_in,
  input  wire logic        block_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  output logic [31:0]      rd_data_out,
  output logic             breaker_fail_pickup_out,
  output logic             retrip_out,
  output logic             breaker_fail_trip_out,
  output logic             blocked_out
);

  // Internal reset, released through two flip-flops.
  logic            rst_meta_q;
  logic            rst_n_q;

  // Settings, sampled inputs, condition code and read data.
  bf_pkg::cfg_t    cfg_q;
  bf_pkg::cfg_t    cfg_d;
  bf_pkg::sense_t  sense;
  bf_pkg::cond_t   cond_q;
  bf_pkg::cond_t   cond_d;
  logic [31:0]     rd_data_q;
  logic [31:0]     rd_data_d;

  // Output registers and their next values.
  logic            pickup_q;
  logic            pickup_d;
  logic            retrip_q;
  logic            retrip_d;
  logic            bf_q;
  logic            bf_d;
  logic            blocked_q;
  logic            blocked_d;

  // Criterion, timer control and timer results.
  logic            current_over;
  logic            pickup_raw;
  logic            run;
  logic            rt_run;
  logic            tick;
  logic [1:0]      tmr_run;
  logic [19:0]     tmr_limit [2];
  logic [1:0]      tmr_done;
  logic            rt_done;
  logic            bf_done;

  // Reset release through two flip-flops; assertion stays asynchronous. The outputs drive trip
  // coils, so they must fall as soon as reset is applied, but a release close to a clock edge
  // must not let some counters leave reset a cycle before the others. Only the second
  // flip-flop is read by the rest of the design.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Inputs are synchronous to the clock and are gathered as one bundle.
  // No synchroniser is placed here; the flags come from logic on this same clock, and a flag
  // that arrives from elsewhere must be synchronised before it reaches these pins.
  assign sense.phase_over    = phase_over_in;
  assign sense.residual_over = residual_over_in;
  assign sense.trip_monitor  = trip_monitor_in;
  assign sense.block         = block_in;
  assign current_over        = sense.phase_over | sense.residual_over;

  // Pick-up condition of the selected criterion. Current only ignores the trip monitor altogether.
  // Current and trip needs both at once, so a trip contact that drops out resets the timers even
  // while current still flows. Current or trip holds the pick-up until both have gone, which keeps
  // supervising a breaker whose current has fallen while the trip command still stands.
  always_comb begin
    unique case (cfg_q.mode)
      bf_pkg::MODE_CUR_AND_DO: begin
        // Timers stay at zero while the current is high and the trip is not yet seen.
        pickup_raw = current_over & sense.trip_monitor;
      end
      bf_pkg::MODE_CUR_OR_DO: begin
        // Either cause alone keeps the timers running.
        pickup_raw = current_over | sense.trip_monitor;
      end
      bf_pkg::MODE_CURRENT: begin
        // The trip monitor plays no part here.
        pickup_raw = current_over;
      end
      default: begin
        pickup_raw = current_over; // Illegal code falls back to current only.
      end
    endcase
  end

  // The block input suppresses timing and releases a start already running.
  // Blocked is shown only while a pick-up is present, so a block held on a quiet feeder stays silent.
  assign run    = pickup_raw & ~sense.block;
  assign rt_run = run & cfg_q.retrip_en;

  // One step tick source is shared, since the same pick-up starts both timers.
  // The step count is 18 bits wide, enough for a 5 ms step at the 50 MHz clock. A shorter step may
  // be set for simulation through the parameter.
  step_tick_gen #(
    .STEP_CYCLES (18'(STEP_CYCLES))
  ) u_tick (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_q),
    .run_in   (run),
    .tick_out (tick)
  );

  // Per-timer run and limit: index 0 is the retrip timer, which runs only while retrip is enabled,
  // and index 1 the breaker-failure timer. With retrip off the retrip limit is simply never used.
  assign tmr_run[0]   = rt_run;
  assign tmr_run[1]   = run;
  assign tmr_limit[0] = cfg_q.retrip_delay_setting;
  assign tmr_limit[1] = cfg_q.bf_delay;

  // One delay timer per trip output; both count the shared tick from the same start, each to its own limit.
  for (genvar i = 0; i < 2; i++) begin : g_timer
    delay_timer u_timer (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_q),
      .run_in   (tmr_run[i]),
      .tick_in  (tick),
      .limit_in (tmr_limit[i]),
      .done_out (tmr_done[i])
    );
  end

  // Done flags back under their own names for the output logic.
  assign rt_done = tmr_done[0];
  assign bf_done = tmr_done[1];

  // Output next values; all drop at the same edge that clears the timers.
  // The condition code takes the status priority: blocked, then breaker fail, then retrip,
  // then start. Turning retrip off during a fault drops the retrip output at the next edge.
  always_comb begin
    pickup_d  = run;
    retrip_d  = rt_run & rt_done;
    bf_d      = run & bf_done;
    blocked_d = pickup_raw & sense.block;
    if (blocked_d) begin
      cond_d = bf_pkg::COND_BLOCKED;
    end else if (bf_d) begin
      cond_d = bf_pkg::COND_BF_ON;
    end else if (retrip_d) begin
      cond_d = bf_pkg::COND_RETRIP;
    end else if (pickup_d) begin
      cond_d = bf_pkg::COND_START;
    end else begin
      cond_d = bf_pkg::COND_NORMAL;
    end
  end

  // Output registers. Every pin leaves a flip-flop, so a glitch in the criterion logic can never
  // pulse a trip coil, at the price of one cycle of latency on every indication.
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pickup_q  <= 1'b0;
      retrip_q  <= 1'b0;
      bf_q      <= 1'b0;
      blocked_q <= 1'b0;
      cond_q    <= bf_pkg::COND_NORMAL;
    end else begin
      pickup_q  <= pickup_d;
      retrip_q  <= retrip_d;
      bf_q      <= bf_d;
      blocked_q <= blocked_d;
      cond_q    <= cond_d;
    end
  end

  // Register writes; a setting changed during a pick-up takes effect at once.
  // The control word holds the criterion in its two low bits and the retrip enable in bit 2;
  // criterion code 3 is not defined and acts as current only rather than stopping supervision.
  // The retrip and breaker-failure words each hold a delay of up to 20 bits, counted in steps,
  // so the longest setting is a little over 87 minutes at the 5 ms step.
  // Writes to the status word or to an unmapped address change nothing, and the port never stalls.
  always_comb begin
    cfg_d = cfg_q;
    if (wr_en_in) begin
      unique case (addr_in)
        bf_pkg::OFS_CTRL: begin
          cfg_d.mode      = wr_data_in[bf_pkg::CTRL_MODE_LSB +: 2];
          cfg_d.retrip_en = wr_data_in[bf_pkg::CTRL_RT_EN];
        end
        bf_pkg::OFS_RETRIP: begin
          cfg_d.retrip_delay_setting = wr_data_in[bf_pkg::DELAY_W-1:0];
        end
        bf_pkg::OFS_BF: begin
          cfg_d.bf_delay = wr_data_in[bf_pkg::DELAY_W-1:0];
        end
        default: begin
          cfg_d = cfg_q; // Writes elsewhere are ignored.
        end
      endcase
    end
  end

  // Register reads; data stand only in the cycle after the strobe.
  // Outside that cycle the read data are zero, so a bus that ORs several slaves together needs no
  // extra gating. Status shows the one-hot condition in bits 4:0 and the live input flags in 11:8.
  always_comb begin
    rd_data_d = 32'h0000_0000;
    if (rd_en_in) begin
      unique case (addr_in)
        bf_pkg::OFS_CTRL: begin
          rd_data_d[bf_pkg::CTRL_MODE_LSB +: 2] = cfg_q.mode;
          rd_data_d[bf_pkg::CTRL_RT_EN]         = cfg_q.retrip_en;
        end
        bf_pkg::OFS_RETRIP: begin
          rd_data_d[bf_pkg::DELAY_W-1:0] = cfg_q.retrip_delay_setting;
        end
        bf_pkg::OFS_BF: begin
          rd_data_d[bf_pkg::DELAY_W-1:0] = cfg_q.bf_delay;
        end
        bf_pkg::OFS_STATUS: begin
          // Condition and raw flags are taken at the strobe edge, like every other word.
          rd_data_d[bf_pkg::STAT_COND_LSB +: 5] = cond_q;
          rd_data_d[bf_pkg::STAT_PH_BIT]        = sense.phase_over;
          rd_data_d[bf_pkg::STAT_RES_BIT]       = sense.residual_over;
          rd_data_d[bf_pkg::STAT_TRIP_BIT]      = sense.trip_monitor;
          rd_data_d[bf_pkg::STAT_BLK_BIT]       = sense.block;
        end
        default: begin
          rd_data_d = 32'h0000_0000; // Unmapped addresses read as zero.
        end
      endcase
    end
  end

  // Register file and read data registers.
  // Reset brings back current only with retrip on and the default delays, so a unit that restarts
  // without software still supervises its breaker.
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_q.mode                 <= bf_pkg::MODE_CURRENT;
      cfg_q.retrip_en            <= bf_pkg::RT_EN_DEF;
      cfg_q.retrip_delay_setting <= bf_pkg::RETRIP_DEF;
      cfg_q.bf_delay             <= bf_pkg::BF_DEF;
      rd_data_q                  <= 32'h0000_0000;
    end else begin
      cfg_q     <= cfg_d;
      rd_data_q <= rd_data_d;
    end
  end

  // Top-level pins taken straight from their registers.
  assign rd_data_out             = rd_data_q;
  assign breaker_fail_pickup_out = pickup_q;
  assign retrip_out              = retrip_q;
  assign breaker_fail_trip_out   = bf_q;
  assign blocked_out             = blocked_q;

endmodule : breaker_fail_timer_logic

// file: bench/bf_checker_properties.sv
// Port-level assertions of the breaker-failure timer logic, bound to its top.
`timescale 1ns/100ps
module bf_checker #(
  parameter int unsigned STEP_CYCLES = 4
) (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic        phase_over_in,
  input wire logic        residual_over_in,
  input wire logic        trip_monitor_in,
  input wire logic        block_in,
  input wire logic [7:0]  addr_in,
  input wire logic        rd_en_in,
  input wire logic [31:0] rd_data_out,
  input wire logic        breaker_fail_pickup_out,
  input wire logic        retrip_out,
  input wire logic        breaker_fail_trip_out,
  input wire logic        blocked_out
);
  logic [3:0] sense;

  // Inputs in the order the status word shows them.
  assign sense = {block_in, trip_monitor_in, residual_over_in, phase_over_in};

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // No criterion picks up without current and without trip indication.
  idle_no_pickup_a:
  assert property (!phase_over_in && !residual_over_in && !trip_monitor_in |=> !breaker_fail_pickup_out)
    else $error("pickup without any cause");
  // Blocking clears start and both trip outputs on the next edge.
  block_clears_a:
  assert property (block_in |=> !breaker_fail_pickup_out && !retrip_out && !breaker_fail_trip_out)
    else $error("block did not clear outputs");
  retrip_in_pickup_a:
  assert property (retrip_out |-> breaker_fail_pickup_out)
    else $error("retrip without pickup");
  bf_in_pickup_a:
  assert property (breaker_fail_trip_out |-> breaker_fail_pickup_out)
    else $error("breaker fail without pickup");
  blocked_cause_a:
  assert property (blocked_out |-> $past(block_in) && !breaker_fail_pickup_out)
    else $error("blocked shown without block");
  start_unblocked_a:
  assert property (breaker_fail_pickup_out |-> !$past(block_in))
    else $error("start shown while blocked");
  // Read data stand only in the cycle after a read strobe.
  rd_idle_zero_a:
  assert property (!$past(rd_en_in) |-> rd_data_out == 32'h0000_0000)
    else $error("read data outside read cycle");
  status_inputs_a:
  assert property (rd_en_in && addr_in == bf_pkg::OFS_STATUS && $stable(sense) |=> rd_data_out[11:8] == $past(sense))
    else $error("status inputs wrong");
  unmapped_zero_a:
  assert property (rd_en_in && addr_in[1:0] != 2'b00 |=> rd_data_out == 32'h0000_0000)
    else $error("unmapped read not zero");

  cover property ($rose(retrip_out));
  cover property ($rose(breaker_fail_trip_out));
  cover property (blocked_out);
  cover property (rd_en_in && addr_in == bf_pkg::OFS_STATUS);
endmodule : bf_checker

bind breaker_fail_timer_logic bf_checker #(.STEP_CYCLES(STEP_CYCLES)) chk (.clk_in(clk_in), .nrst_in(nrst_in),
  .phase_over_in(phase_over_in), .residual_over_in(residual_over_in), .trip_monitor_in(trip_monitor_in),
  .block_in(block_in), .addr_in(addr_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
  .breaker_fail_pickup_out(breaker_fail_pickup_out), .retrip_out(retrip_out),
  .breaker_fail_trip_out(breaker_fail_trip_out), .blocked_out(blocked_out));

// file: bench/feeder_model.sv
// Model of the protected feeder: fault currents, primary trip contact and breakers.
`timescale 1ns/100ps
module feeder_model (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic [1:0] fault_in,
  input  wire logic       trip_cmd_in,
  input  wire logic       open_en_in,
  input  wire logic       retrip_in,
  input  wire logic       bf_trip_in,
  output logic            phase_over_out,
  output logic            residual_over_out,
  output logic            trip_monitor_out
);
  logic open_d;
  logic open_q;

  // A working coil opens the breaker a cycle after a trip; it recloses once the fault is gone.
  always_comb begin
    open_d = (open_q | (open_en_in & (retrip_in | bf_trip_in))) & (|fault_in);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      open_q <= 1'b0;
    end else begin
      open_q <= open_d;
    end
  end

  // Current flows only while the fault is fed; the contact follows the primary command.
  assign phase_over_out    = fault_in[0] & ~open_q;
  assign residual_over_out = fault_in[1] & ~open_q;
  assign trip_monitor_out  = trip_cmd_in;
endmodule : feeder_model

// file: bench/tb_top.sv
// Self-checking testbench of the breaker-failure timer logic.
`timescale 1ns/100ps
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        block_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wr_data_in = 32'h0000_0000;
  logic        wr_en_in = 1'b0;
  logic        rd_en_in = 1'b0;
  logic [1:0]  fault = 2'b00;
  logic        trip_cmd = 1'b0;
  logic        open_en = 1'b0;
  logic [31:0] rd_data_out;
  logic [31:0] rdv;
  logic        pickup, retrip, bf_trip, blocked, ph, res, mon;
  int          error_cnt = 0;
  int          compares = 0;

  always #10 clk_in = ~clk_in;

  // Step of four cycles keeps every delay short.
  breaker_fail_timer_logic #(.STEP_CYCLES(4)) dut (.clk_in(clk_in), .nrst_in(nrst_in), .phase_over_in(ph),
    .residual_over_in(res), .trip_monitor_in(mon), .block_in(block_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
    .breaker_fail_pickup_out(pickup), .retrip_out(retrip), .breaker_fail_trip_out(bf_trip),
    .blocked_out(blocked));
  feeder_model feeder (.clk_in(clk_in), .nrst_in(nrst_in), .fault_in(fault), .trip_cmd_in(trip_cmd),
    .open_en_in(open_en), .retrip_in(retrip), .bf_trip_in(bf_trip), .phase_over_out(ph),
    .residual_over_out(res), .trip_monitor_out(mon));

  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // Bus cycles; strobes last one cycle and read data are taken in the following cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_en_in   <= 1'b1;
    @(posedge clk_in);
    wr_en_in   <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1;
    d = rd_data_out;
  endtask : rd

  // Apply fault and trip command at one edge, which then counts as cycle zero.
  task automatic go(input logic [1:0] f, input logic t);
    @(posedge clk_in);
    fault    <= f;
    trip_cmd <= t;
  endtask : go

  task automatic chk_at(input int n, input logic [2:0] e);
    repeat (n) @(posedge clk_in);
    #1;
    `CHECK({pickup, retrip, bf_trip}, e)
  endtask : chk_at

  // Retrip near ten cycles, breaker fail near eighteen, with two cycles of slack either side.
  task automatic profile(input logic rt);
    chk_at(7, 3'b100);
    chk_at(5, {1'b1, rt, 1'b0});
    chk_at(3, {1'b1, rt, 1'b0});
    chk_at(5, {1'b1, rt, 1'b1});
  endtask : profile

  task automatic drop(input logic [1:0] f, input logic t, input string name);
    go(f, t);
    chk_at(1, 3'b000);
    go(2'b00, 1'b0);
    $display("%s done, errors %0d", name, error_cnt);
  endtask : drop

  task automatic t_regs;
    rd(bf_pkg::OFS_CTRL, rdv);
    `CHECK(rdv, 32'h0000_0004)
    rd(bf_pkg::OFS_RETRIP, rdv);
    `CHECK(rdv, 32'h0000_0014)
    rd(bf_pkg::OFS_BF, rdv);
    `CHECK(rdv, 32'h0000_0028)
    rd(8'h10, rdv);
    `CHECK(rdv, 32'h0000_0000)
    rd(8'h05, rdv);
    `CHECK(rdv, 32'h0000_0000)
    wr(bf_pkg::OFS_RETRIP, 32'h0000_0002);
    wr(bf_pkg::OFS_BF, 32'h0000_0004);
    rd(bf_pkg::OFS_RETRIP, rdv);
    `CHECK(rdv, 32'h0000_0002)
    $display("regs done, errors %0d", error_cnt);
  endtask : t_regs

  // Current only, also through the illegal code that falls back to it.
  task automatic t_cur(input logic [1:0] m);
    wr(bf_pkg::OFS_CTRL, 32'(m) | 32'h0000_0004);
    go(2'b00, 1'b1);
    chk_at(20, 3'b000);
    go(2'b01, 1'b1);
    profile(1'b1);
    rd(bf_pkg::OFS_STATUS, rdv);
    `CHECK(rdv[11:0], 12'h508)
    drop(2'b00, 1'b1, "current");
  endtask : t_cur

  task automatic t_and;
    wr(bf_pkg::OFS_CTRL, 32'h0000_0005);
    go(2'b01, 1'b0);
    chk_at(20, 3'b000);
    go(2'b01, 1'b1);
    profile(1'b1);
    drop(2'b01, 1'b0, "current and trip");
  endtask : t_and

  task automatic t_or;
    wr(bf_pkg::OFS_CTRL, 32'h0000_0006);
    go(2'b00, 1'b1);
    profile(1'b1);
    go(2'b10, 1'b0);
    chk_at(3, 3'b111);
    drop(2'b00, 1'b0, "current or trip");
  endtask : t_or

  task automatic t_noretrip;
    wr(bf_pkg::OFS_CTRL, 32'h0000_0000);
    go(2'b11, 1'b0);
    profile(1'b0);
    drop(2'b00, 1'b0, "no retrip");
  endtask : t_noretrip

  task automatic t_block;
    wr(bf_pkg::OFS_CTRL, 32'h0000_0004);
    go(2'b01, 1'b0);
    chk_at(3, 3'b100);
    @(posedge clk_in);
    block_in <= 1'b1;
    chk_at(20, 3'b000);
    `CHECK(blocked, 1'b1)
    rd(bf_pkg::OFS_STATUS, rdv);
    `CHECK(rdv[11:0], 12'h910)
    @(posedge clk_in);
    block_in <= 1'b0;
    profile(1'b1);
    drop(2'b00, 1'b0, "block");
  endtask : t_block

  // A good redundant coil clears the fault, so breaker fail never follows the retrip.
  task automatic t_cleared;
    open_en <= 1'b1;
    go(2'b01, 1'b0);
    chk_at(20, 3'b000);
    open_en <= 1'b0;
    drop(2'b00, 1'b0, "cleared by retrip");
  endtask : t_cleared

  initial begin
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_regs();
    t_cur(2'b00);
    t_cur(2'b11);
    t_and();
    t_or();
    t_noretrip();
    t_block();
    t_cleared();
    end_of_test();
  end

  // The tests need well under a thousand cycles, so this limit only cuts a hang short.
  initial begin
    repeat (5000) @(posedge clk_in);
    error_cnt++;
    end_of_test();
  end
endmodule : tb_top
